// [src/uiofm_defs.vh]
/*
 * Constants of the user I/O function mapper: register offsets, field
 * positions, reset values, function and state codes, timing counts.
 * Assumes it is included by bare name into each file that uses it.
 */
`ifndef UIOFM_DEFS_VH
`define UIOFM_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define UIOFM_ADDR_CTRL 4'h0
`define UIOFM_ADDR_INMAP 4'h1
`define UIOFM_ADDR_OUTMAP 4'h2
`define UIOFM_ADDR_STATUS 4'h3
`define UIOFM_ADDR_IRQ_STAT 4'h4
`define UIOFM_ADDR_IRQ_MASK 4'h5

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define UIOFM_CTRL_START 0
`define UIOFM_CTRL_STOP 1
`define UIOFM_CTRL_CLEAR 2
`define UIOFM_CTRL_LOCK 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UIOFM_INMAP_RST 16'h0001
`define UIOFM_OUTMAP_RST 32'h0000_0431
`define UIOFM_MASK_RST 5'h00

// ----------------------------------------------------------------
// Input function codes (4 bits per input)
// ----------------------------------------------------------------
`define UIOFM_FN_NONE 4'h0
`define UIOFM_FN_RUN 4'h1
`define UIOFM_FN_INTERLOCK 4'h2
`define UIOFM_FN_CLEAR 4'h3
`define UIOFM_FN_LOCK 4'h4
`define UIOFM_FN_START 4'h5
`define UIOFM_FN_STOP 4'h6

// ----------------------------------------------------------------
// Output state codes (index into the state vector)
// ----------------------------------------------------------------
`define UIOFM_ST_OFF 4'h0
`define UIOFM_ST_ENABLED 4'h1
`define UIOFM_ST_STBY_FAULT 4'h2
`define UIOFM_ST_STANDBY 4'h3
`define UIOFM_ST_FAULT 4'h4
`define UIOFM_ST_CV 4'h5
`define UIOFM_ST_CC 4'h6
`define UIOFM_ST_CP 4'h7
`define UIOFM_ST_CR 4'h8
`define UIOFM_ST_LOCK 4'h9
`define UIOFM_NUM_STATES 16

// ----------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------
`define UIOFM_EV_FAULT 0
`define UIOFM_EV_STOPPED 1
`define UIOFM_EV_STARTED 2
`define UIOFM_EV_INTERLOCK 3
`define UIOFM_EV_MOMENTARY 4
`define UIOFM_NUM_EV 5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UIOFM_CLK_MHZ 40
`define UIOFM_MOM_MIN_US 3000
`define UIOFM_MOM_CYCLES (`UIOFM_MOM_MIN_US * `UIOFM_CLK_MHZ)

`endif

// [src/uiofm_in_chan.v]
/*
 * One digital input channel: two-stage synchroniser, settled level, and a
 * momentary pulse issued once the input has stayed high for the minimum time.
 * Assumes the pin is asynchronous to i_sys_clk and i_ce gates all state.
 */
`timescale 1ns/10ps
module uiofm_in_chan #(
    parameter MOM_CYCLES = 120000,
    parameter CW = 20
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_pin,
    output reg o_level,
    output reg o_rise,
    output reg o_mom_pulse
);

localparam integer MOM_LAST_I = MOM_CYCLES - 1;
localparam [CW-1:0] MOM_LAST = MOM_LAST_I[CW-1:0];

reg sync1_reg;
reg level_d_reg;
reg [CW-1:0] cnt_reg;
reg fired_reg;

// Synchroniser, level, rise detect and high-time qualifier
always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
        sync1_reg <= 1'b0;
        o_level <= 1'b0;
        o_rise <= 1'b0;
        level_d_reg <= 1'b0;
        o_mom_pulse <= 1'b0;
        cnt_reg <= {CW{1'b0}};
        fired_reg <= 1'b0;
    end else if (i_ce) begin
        sync1_reg <= i_pin;
        o_level <= sync1_reg;
        level_d_reg <= o_level;
        o_rise <= o_level & ~level_d_reg; // Only the second stage feeds logic
        o_mom_pulse <= 1'b0;
        if (!o_level) begin
            cnt_reg <= {CW{1'b0}};
            fired_reg <= 1'b0;
        end else if (!fired_reg) begin
            if (cnt_reg == MOM_LAST) begin
                o_mom_pulse <= 1'b1;
                fired_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
end

endmodule // uiofm_in_chan

// [src/uiofm_out_sel.v]
/*
 * One digital output: picks one internal state by its 4-bit code and
 * registers it onto the pin.
 * Assumes the state vector is on the same clock; i_ce gates the flop.
 */
`timescale 1ns/10ps
`include "uiofm_defs.vh"
module uiofm_out_sel (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire [3:0] i_sel,
    input wire [`UIOFM_NUM_STATES-1:0] i_states,
    output reg o_pin
);

// High while the chosen state is active, low otherwise
always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
        o_pin <= 1'b0;
    end else if (i_ce) begin
        o_pin <= i_states[i_sel];
    end
end

endmodule // uiofm_out_sel

// [src/uiofm_top.v]
/*
 * User I/O function mapper: four reassignable digital inputs driving run,
 * interlock, fault clear, keypad lock, start and stop; eight reassignable
 * digital outputs reporting internal states; a small register file with
 * a sticky, maskable interrupt.
 * Assumes pins are asynchronous, all other inputs are on i_sys_clk, and
 * the register master follows the one-cycle strobe protocol.
 */
// Summary of operation
// - A stop request always beats a simultaneous start request.
// - Four digital inputs, each routed to a function chosen by a register.
// - Momentary functions fire on a rising edge held high 3 ms or longer.
// - Normally-closed functions need the input high and trigger as it goes low.
// - Active-when-present functions stay asserted exactly while the input is high.
// - Run input is edge start, level stop: a rising edge runs, low stops.
// - Interlock is normally closed; dropping it stops operation.
// - Fault clear removes the latched fault only if the cause is gone.
// - Keypad lock active blocks all front panel key presses.
// - Eight digital outputs, each reporting a state chosen by a register.
// - Each output is high while its state is active, low otherwise.
// - Enabled means input stage engaged and power being processed.
// - Standby-or-fault is the OR of standby and fault.
// - Separate standby-only and fault-only indications.
// - Four regulation-mode indications: voltage, current, power, resistance.
// - Lock indication is active while keypad lock is engaged.
`timescale 1ns/10ps
`include "uiofm_defs.vh"
module uiofm_top #(
    parameter N_IN = 4,
    parameter N_OUT = 8,
    parameter N_KEYS = 8,
    parameter MOM_CYCLES = `UIOFM_MOM_CYCLES
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire [N_IN-1:0] i_din,
    input wire i_fault_cond,
    input wire i_power_active,
    input wire i_const_voltage,
    input wire i_const_current,
    input wire i_const_power,
    input wire i_const_resistance,
    input wire [N_KEYS-1:0] i_key_press,
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    output wire [N_OUT-1:0] o_dout,
    output reg o_input_engaged,
    output reg o_fault,
    output reg o_locked,
    output reg [N_KEYS-1:0] o_key_press,
    output reg o_irq
);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [4*N_IN-1:0] inmap_reg;
reg [4*N_OUT-1:0] outmap_reg;
reg sw_lock_reg;
reg [`UIOFM_NUM_EV-1:0] irq_stat_reg;
reg [`UIOFM_NUM_EV-1:0] irq_mask_reg;
reg [`UIOFM_NUM_EV-1:0] irq_stat_next;
reg intlk_trip_d_reg;

// ----------------------------------------------------------------
// Input channels
// ----------------------------------------------------------------
wire [N_IN-1:0] in_level;
wire [N_IN-1:0] in_rise;
wire [N_IN-1:0] in_mom;
wire [N_IN-1:0] is_run;
wire [N_IN-1:0] is_intlk;
wire [N_IN-1:0] is_clear;
wire [N_IN-1:0] is_lock;
wire [N_IN-1:0] is_start;
wire [N_IN-1:0] is_stop;

genvar gi;
generate
    for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_in
        uiofm_in_chan #(
            .MOM_CYCLES(MOM_CYCLES)
        ) u_chan (
            .i_sys_clk(i_sys_clk),
            .i_rstn(i_rstn),
            .i_ce(i_ce),
            .i_pin(i_din[gi]),
            .o_level(in_level[gi]),
            .o_rise(in_rise[gi]),
            .o_mom_pulse(in_mom[gi])
        );
        // Function routing is a register field, not wiring
        assign is_run[gi] = (inmap_reg[4*gi +: 4] == `UIOFM_FN_RUN);
        assign is_intlk[gi] = (inmap_reg[4*gi +: 4] == `UIOFM_FN_INTERLOCK);
        assign is_clear[gi] = (inmap_reg[4*gi +: 4] == `UIOFM_FN_CLEAR);
        assign is_lock[gi] = (inmap_reg[4*gi +: 4] == `UIOFM_FN_LOCK);
        assign is_start[gi] = (inmap_reg[4*gi +: 4] == `UIOFM_FN_START);
        assign is_stop[gi] = (inmap_reg[4*gi +: 4] == `UIOFM_FN_STOP);
    end
endgenerate

// ----------------------------------------------------------------
// Function evaluation
// ----------------------------------------------------------------
// Active-when-present functions follow the level directly
wire run_asg = |is_run;
wire run_high = |(is_run & in_level);
wire run_rise = |(is_run & in_rise);
wire clear_pin = |(is_clear & in_level);
wire lock_pin = |(is_lock & in_level);

// Normally closed: any assigned input low trips
wire intlk_trip = |(is_intlk & ~in_level);

// Momentary functions use the qualified high-time pulse
wire start_pin = |(is_start & in_mom);
wire stop_pin = |(is_stop & in_mom);

// Software command strobes from the control register
wire ctrl_wr = i_wr && (i_addr == `UIOFM_ADDR_CTRL);
wire sw_start = ctrl_wr & i_wdata[`UIOFM_CTRL_START];
wire sw_stop = ctrl_wr & i_wdata[`UIOFM_CTRL_STOP];
wire sw_clear = ctrl_wr & i_wdata[`UIOFM_CTRL_CLEAR];

// Anything that halts operation
wire stop_any = sw_stop | stop_pin | intlk_trip | o_fault | (run_asg & ~run_high);
wire start_any = sw_start | start_pin | run_rise;

// Fault can only be cleared once its causes are gone
wire clear_req = clear_pin | sw_clear;
wire fault_cause = i_fault_cond | intlk_trip;
wire lock_now = lock_pin | sw_lock_reg;

// ----------------------------------------------------------------
// Operating state
// ----------------------------------------------------------------
// Input engage, fault latch, lock and key gating
always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
        o_input_engaged <= 1'b0;
        o_fault <= 1'b0;
        o_locked <= 1'b0;
        o_key_press <= {N_KEYS{1'b0}};
        intlk_trip_d_reg <= 1'b0;
    end else if (i_ce) begin
        if (stop_any) begin
            o_input_engaged <= 1'b0;
        end else if (start_any) begin
            o_input_engaged <= 1'b1;
        end
        if (fault_cause) begin
            o_fault <= 1'b1;
        end else if (clear_req) begin
            o_fault <= 1'b0;
        end
        o_locked <= lock_now;
        o_key_press <= lock_now ? {N_KEYS{1'b0}} : i_key_press;
        intlk_trip_d_reg <= intlk_trip;
    end
end

// ----------------------------------------------------------------
// State vector for the outputs
// ----------------------------------------------------------------
wire st_enabled = o_input_engaged & i_power_active;
wire st_fault = o_fault;
wire st_standby = ~o_input_engaged & ~o_fault;
wire st_stby_fault = st_standby | st_fault;
reg [`UIOFM_NUM_STATES-1:0] states;

// Gather each reportable state at its code position
always @* begin
    states = {`UIOFM_NUM_STATES{1'b0}};
    states[`UIOFM_ST_ENABLED] = st_enabled;
    states[`UIOFM_ST_STBY_FAULT] = st_stby_fault;
    states[`UIOFM_ST_STANDBY] = st_standby;
    states[`UIOFM_ST_FAULT] = st_fault;
    states[`UIOFM_ST_CV] = i_const_voltage;
    states[`UIOFM_ST_CC] = i_const_current;
    states[`UIOFM_ST_CP] = i_const_power;
    states[`UIOFM_ST_CR] = i_const_resistance;
    states[`UIOFM_ST_LOCK] = lock_now;
end

// ----------------------------------------------------------------
// Output channels
// ----------------------------------------------------------------
genvar go;
generate
    for (go = 0; go < N_OUT; go = go + 1) begin : g_out
        uiofm_out_sel u_sel (
            .i_sys_clk(i_sys_clk),
            .i_rstn(i_rstn),
            .i_ce(i_ce),
            .i_sel(outmap_reg[4*go +: 4]),
            .i_states(states),
            .o_pin(o_dout[go])
        );
    end
endgenerate

// ----------------------------------------------------------------
// Interrupt events
// ----------------------------------------------------------------
wire [`UIOFM_NUM_EV-1:0] events;
assign events[`UIOFM_EV_FAULT] = fault_cause & ~o_fault;
assign events[`UIOFM_EV_STOPPED] = stop_any & o_input_engaged;
assign events[`UIOFM_EV_STARTED] = ~stop_any & start_any & ~o_input_engaged;
assign events[`UIOFM_EV_INTERLOCK] = intlk_trip & ~intlk_trip_d_reg;
assign events[`UIOFM_EV_MOMENTARY] = start_pin | stop_pin;

// Write-one-to-clear, a new event wins over the clear
always @* begin
    irq_stat_next = irq_stat_reg;
    if (i_wr && (i_addr == `UIOFM_ADDR_IRQ_STAT)) begin
        irq_stat_next = irq_stat_next & ~i_wdata[`UIOFM_NUM_EV-1:0];
    end
    irq_stat_next = irq_stat_next | events;
end

// ----------------------------------------------------------------
// Register writes, status and interrupt line
// ----------------------------------------------------------------
always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
        inmap_reg <= `UIOFM_INMAP_RST;
        outmap_reg <= `UIOFM_OUTMAP_RST;
        sw_lock_reg <= 1'b0;
        irq_mask_reg <= `UIOFM_MASK_RST;
        irq_stat_reg <= {`UIOFM_NUM_EV{1'b0}};
        o_irq <= 1'b0;
    end else if (i_ce) begin
        if (i_wr) begin
            if (i_addr == `UIOFM_ADDR_CTRL) begin
                sw_lock_reg <= i_wdata[`UIOFM_CTRL_LOCK];
            end else if (i_addr == `UIOFM_ADDR_INMAP) begin
                inmap_reg <= i_wdata[4*N_IN-1:0];
            end else if (i_addr == `UIOFM_ADDR_OUTMAP) begin
                outmap_reg <= i_wdata[4*N_OUT-1:0];
            end else if (i_addr == `UIOFM_ADDR_IRQ_MASK) begin
                irq_mask_reg <= i_wdata[`UIOFM_NUM_EV-1:0];
            end
        end
        irq_stat_reg <= irq_stat_next;
        o_irq <= |(irq_stat_next & irq_mask_reg);
    end
end

// ----------------------------------------------------------------
// Register reads: data stands only in the cycle after the strobe
// ----------------------------------------------------------------
always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
        o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
        o_rdata <= 32'h0000_0000;
        if (i_rd) begin
            if (i_addr == `UIOFM_ADDR_CTRL) begin
                o_rdata[`UIOFM_CTRL_LOCK] <= sw_lock_reg;
            end else if (i_addr == `UIOFM_ADDR_INMAP) begin
                o_rdata[4*N_IN-1:0] <= inmap_reg;
            end else if (i_addr == `UIOFM_ADDR_OUTMAP) begin
                o_rdata[4*N_OUT-1:0] <= outmap_reg;
            end else if (i_addr == `UIOFM_ADDR_STATUS) begin
                o_rdata[0] <= st_enabled;
                o_rdata[1] <= st_standby;
                o_rdata[2] <= st_fault;
                o_rdata[3] <= lock_now;
                o_rdata[4] <= ~intlk_trip;
                o_rdata[5] <= o_input_engaged;
                o_rdata[11:8] <= in_level[3:0];
                o_rdata[23:16] <= o_dout[7:0];
            end else if (i_addr == `UIOFM_ADDR_IRQ_STAT) begin
                o_rdata[`UIOFM_NUM_EV-1:0] <= irq_stat_reg;
            end else if (i_addr == `UIOFM_ADDR_IRQ_MASK) begin
                o_rdata[`UIOFM_NUM_EV-1:0] <= irq_mask_reg;
            end
        end
    end
end

endmodule // uiofm_top

// [dv/uiofm_plc_model.sv]
/*
 * External controller model: drives the four rear digital inputs.
 * Assumes the bench calls its tasks; pins change just after a clock edge.
 */
`timescale 1ns/10ps
module uiofm_plc_model (
    input wire i_sys_clk,
    output logic [3:0] o_din
);
    // Open contacts sit at the pull-down level
    initial o_din = 4'h0;

    // Hold one pin at a level, set on the next clock edge
    task automatic set_pin(input int idx, input logic val);
        @(posedge i_sys_clk);
        o_din[idx] <= val;
    endtask

    // Momentary pulse, long or short of the minimum hold
    task automatic pulse(input int idx, input int len);
        set_pin(idx, 1'b1);
        repeat (len) @(posedge i_sys_clk);
        o_din[idx] <= 1'b0;
    endtask
endmodule // uiofm_plc_model

// [dv/uiofm_checker.sv]
/*
 * Checker: output state mapping, keypad blocking and fault latch of uiofm_top.
 * Assumes it is bound to uiofm_top; its shadows freeze with i_ce like the design.
 */
`timescale 1ns/10ps
`include "uiofm_defs.vh"
module uiofm_checker #(
    parameter N_OUT = 8,
    parameter N_KEYS = 8
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_fault_cond,
    input wire i_power_active,
    input wire i_const_voltage,
    input wire i_const_current,
    input wire i_const_power,
    input wire i_const_resistance,
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire [N_OUT-1:0] o_dout,
    input wire o_input_engaged,
    input wire o_fault,
    input wire o_locked,
    input wire [N_KEYS-1:0] o_key_press
);
    logic [31:0] map_reg;
    logic [3:0] up_cnt;
    logic [15:0] st;
    logic [N_OUT-1:0] exp_reg;
    logic [N_OUT-1:0] m_code [16];
    logic standby;
    logic ready;

    // ------------------------------------------------------------
    // Shadow output map and expected output levels
    // ------------------------------------------------------------
    assign standby = !o_input_engaged && !o_fault;
    assign st = {6'h00, o_locked, i_const_resistance, i_const_power, i_const_current, i_const_voltage,
                 o_fault, standby, standby || o_fault, o_input_engaged && i_power_active, 1'b0};
    assign ready = up_cnt > 4'h3;

    // Map shadow, settle counter, per-code output masks
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            map_reg <= `UIOFM_OUTMAP_RST;
            up_cnt <= 4'h0;
        end else begin
            if (i_wr && i_ce && i_addr == `UIOFM_ADDR_OUTMAP) begin
                map_reg <= i_wdata;
            end
            if (up_cnt != 4'hF) begin
                up_cnt <= up_cnt + 4'h1;
            end
        end
        if (i_ce) begin
            for (int j = 0; j < N_OUT; j++) begin
                exp_reg[j] <= st[map_reg[4*j +: 4]];
                for (int c = 0; c < 16; c++) begin
                    m_code[c][j] <= map_reg[4*j +: 4] == c;
                end
            end
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    property p_out_all; ready |-> ((o_dout ^ exp_reg) & ~m_code[`UIOFM_ST_LOCK]) == '0; endproperty
    a_out_all: assert property (p_out_all) else $error("output level wrong");
    property p_out_en; ready |-> ((o_dout ^ exp_reg) & m_code[`UIOFM_ST_ENABLED]) == '0; endproperty
    a_out_en: assert property (p_out_en) else $error("enabled output wrong");
    property p_out_sf; ready |-> ((o_dout ^ exp_reg) & m_code[`UIOFM_ST_STBY_FAULT]) == '0; endproperty
    a_out_sf: assert property (p_out_sf) else $error("standby or fault output wrong");
    property p_out_sb; ready |-> ((o_dout ^ exp_reg) & (m_code[3] | m_code[4])) == '0; endproperty
    a_out_sb: assert property (p_out_sb) else $error("standby or fault alone wrong");
    property p_out_md; ready |-> ((o_dout ^ exp_reg) & (m_code[5] | m_code[6] | m_code[7] | m_code[8])) == '0;
    endproperty
    a_out_md: assert property (p_out_md) else $error("regulation output wrong");
    property p_out_lk; ready && $stable(o_locked) |-> ((o_dout ^ {N_OUT{o_locked}}) & m_code[9]) == '0; endproperty
    a_out_lk: assert property (p_out_lk) else $error("lock output wrong");
    property p_key_block; o_locked && $past(o_locked) |-> o_key_press == '0; endproperty
    a_key_block: assert property (p_key_block) else $error("key passed while locked");
    property p_fault_sets; i_fault_cond |-> ##[1:3] o_fault; endproperty
    a_fault_sets: assert property (p_fault_sets) else $error("fault not latched");
    property p_fault_hold; o_fault && i_fault_cond |=> o_fault; endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault cleared while present");
endmodule // uiofm_checker

bind uiofm_top uiofm_checker #(.N_OUT(N_OUT), .N_KEYS(N_KEYS)) u_checker (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_fault_cond(i_fault_cond),
    .i_power_active(i_power_active), .i_const_voltage(i_const_voltage), .i_const_current(i_const_current),
    .i_const_power(i_const_power), .i_const_resistance(i_const_resistance), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .o_dout(o_dout), .o_input_engaged(o_input_engaged),
    .o_fault(o_fault), .o_locked(o_locked), .o_key_press(o_key_press));

// [dv/tb_top.sv]
/*
 * Bench for uiofm_top: pins through the controller model, registers over the strobe port.
 * Assumes uiofm_checker binds itself to the top; i_ce drops once to check the freeze.
 */
`timescale 1ns/10ps
`include "uiofm_defs.vh"
module tb_top;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_ce = 1'b1;
    logic i_fault_cond = 1'b0;
    logic i_power_active = 1'b1;
    logic [3:0] modes = 4'h0;
    logic [7:0] i_key_press = 8'h00;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] rd;
    wire [3:0] din;
    wire [31:0] o_rdata;
    wire [7:0] o_dout;
    wire [7:0] o_key_press;
    wire o_input_engaged, o_fault, o_locked, o_irq;
    int mismatches = 0;
    int n_compared = 0;

    always #12.5 i_sys_clk = ~i_sys_clk;

    uiofm_plc_model u_plc (.i_sys_clk(i_sys_clk), .o_din(din));
    uiofm_top #(.MOM_CYCLES(8)) DUT (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_din(din), .i_fault_cond(i_fault_cond),
        .i_power_active(i_power_active), .i_const_voltage(modes[0]), .i_const_current(modes[1]),
        .i_const_power(modes[2]), .i_const_resistance(modes[3]), .i_key_press(i_key_press),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_dout(o_dout),
        .o_input_engaged(o_input_engaged), .o_fault(o_fault), .o_locked(o_locked),
        .o_key_press(o_key_press), .o_irq(o_irq));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic waitn(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        rd = o_rdata;
    endtask
    // One-cycle fault cause
    task automatic fault_blip;
        @(posedge i_sys_clk) i_fault_cond <= 1'b1;
        @(posedge i_sys_clk) i_fault_cond <= 1'b0;
    endtask
    // Output map 9876_5432: sf, standby, fault, four modes, lock
    function automatic logic [7:0] exp_out(logic eng, logic flt, logic lck, logic [3:0] md);
        return {lck, md, flt, !eng && !flt, !eng || flt};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        reg_rd(4'h1);
        chk("inmap", `UIOFM_INMAP_RST, rd);
        reg_rd(4'h2);
        chk("outmap", `UIOFM_OUTMAP_RST, rd);
        waitn(1);
        chk("rdata idle", 32'h0, o_rdata);
        reg_rd(4'hF);
        chk("unmapped", 32'h0, rd);
        chk("dout idle", 8'h02, o_dout);
    endtask
    task automatic t_run;
        u_plc.set_pin(0, 1'b1);
        waitn(1);
        chk("engaged early", 1'b0, o_input_engaged);
        waitn(4);
        chk("engaged", 1'b1, o_input_engaged);
        chk("enabled out", 8'h01, o_dout);
        reg_rd(4'h3);
        chk("status", 32'h0001_0131, rd);
        @(posedge i_sys_clk) i_power_active <= 1'b0;
        waitn(3);
        chk("no power out", 8'h00, o_dout);
        @(posedge i_sys_clk) i_power_active <= 1'b1;
        i_ce <= 1'b0;
        u_plc.set_pin(0, 1'b0);
        waitn(5);
        chk("frozen", 1'b1, o_input_engaged);
        @(posedge i_sys_clk) i_ce <= 1'b1;
        waitn(5);
        chk("run low", 1'b0, o_input_engaged);
    endtask
    task automatic t_mom;
        reg_wr(4'h1, 32'h0000_0650);
        u_plc.pulse(1, 4);
        waitn(14);
        chk("short start", 1'b0, o_input_engaged);
        u_plc.pulse(1, 12);
        waitn(4);
        chk("long start", 1'b1, o_input_engaged);
        fork
            u_plc.pulse(1, 12);
            u_plc.pulse(2, 12);
        join
        waitn(4);
        chk("stop over start", 1'b0, o_input_engaged);
        reg_wr(4'h0, 32'h0000_0003);
        waitn(4);
        chk("sw stop over start", 1'b0, o_input_engaged);
    endtask
    task automatic t_ilock;
        u_plc.set_pin(3, 1'b1);
        reg_wr(4'h1, 32'h0000_2300);
        reg_wr(4'h0, 32'h0000_0001);
        waitn(4);
        chk("ilock start", 1'b1, o_input_engaged);
        u_plc.set_pin(3, 1'b0);
        waitn(5);
        chk("ilock trip", 1'b0, o_input_engaged);
        chk("ilock fault", 1'b1, o_fault);
        u_plc.set_pin(3, 1'b1);
        @(posedge i_sys_clk) i_fault_cond <= 1'b1;
        u_plc.set_pin(2, 1'b1);
        waitn(5);
        chk("clear blocked", 1'b1, o_fault);
        @(posedge i_sys_clk) i_fault_cond <= 1'b0;
        waitn(5);
        chk("clear level", 1'b0, o_fault);
        u_plc.set_pin(2, 1'b0);
        fault_blip;
        waitn(5);
        chk("fault latched", 1'b1, o_fault);
        reg_wr(4'h0, 32'h0000_0004);
        waitn(3);
        chk("sw clear", 1'b0, o_fault);
    endtask
    task automatic t_irq;
        reg_wr(4'h4, 32'h0000_001F);
        fault_blip;
        waitn(3);
        reg_rd(4'h4);
        chk("fault event", 32'h1, rd & 32'h1);
        chk("irq masked", 1'b0, o_irq);
        reg_wr(4'h5, 32'h0000_0001);
        waitn(2);
        chk("irq", 1'b1, o_irq);
        reg_wr(4'h4, 32'h0000_0001);
        waitn(2);
        chk("irq cleared", 1'b0, o_irq);
        reg_wr(4'h0, 32'h0000_0004);
    endtask
    task automatic t_outs;
        reg_wr(4'h2, 32'h9876_5432);
        reg_wr(4'h1, 32'h0000_0040);
        for (int k = 0; k < 4; k++) begin
            @(posedge i_sys_clk) modes <= 4'h1 << k;
            waitn(3);
            chk("mode out", exp_out(1'b0, 1'b0, 1'b0, 4'h1 << k), o_dout);
        end
        @(posedge i_sys_clk) modes <= 4'h0;
        fault_blip;
        waitn(4);
        chk("fault out", exp_out(1'b0, 1'b1, 1'b0, 4'h0), o_dout);
        reg_wr(4'h0, 32'h0000_0004);
        @(posedge i_sys_clk) i_key_press <= 8'hA5;
        u_plc.set_pin(1, 1'b1);
        waitn(5);
        chk("lock out", exp_out(1'b0, 1'b0, 1'b1, 4'h0), o_dout);
        chk("keys locked", 8'h00, o_key_press);
        chk("locked", 1'b1, o_locked);
        u_plc.set_pin(1, 1'b0);
        waitn(5);
        chk("keys free", 8'hA5, o_key_press);
        reg_wr(4'h0, 32'h0000_0008);
        waitn(2);
        chk("sw lock", 1'b1, o_locked);
        chk("keys sw locked", 8'h00, o_key_press);
    endtask

    // Verdict and end of run
    task automatic complete_run;
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        t_reset;
        t_run;
        t_mom;
        t_ilock;
        t_irq;
        t_outs;
        complete_run;
    end

    // Watchdog against a hang
    initial begin
        #(25 * 20000);
        mismatches++;
        complete_run;
    end
endmodule // tb_top
